//--- tws_pkg.sv
// constants and register map for the three-wire serial slave channel
// assumes a 32-bit classic Wishbone slave port and one serial channel per instance
package tws_pkg;
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;   // channel_data_buffer
  localparam logic [7:0] OFS_MODE = 8'h04;   // channel_mode_reg
  localparam logic [7:0] OFS_COMM = 8'h08;   // channel_comm_config_reg
  localparam logic [7:0] OFS_STAT = 8'h0C;   // channel_status_reg
  localparam logic [7:0] OFS_START = 8'h10;  // channel_start_trigger
  localparam logic [7:0] OFS_STOP = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  // mode register fields
  localparam int MODE_EVSEL = 0;
  localparam int MODE_TX_EN = 1;
  localparam int MODE_RX_EN = 2;
  // comm config fields
  localparam int COMM_LEN_LSB = 0;
  localparam int COMM_LEN_W = 5;
  localparam int COMM_CPOL = 8;
  localparam int COMM_DAP = 9;
  localparam int COMM_LSBF = 10;
  // status fields
  localparam int STAT_BFF = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_RXV = 2;
  localparam int STAT_OVF = 3;
  // interrupt status / mask fields
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_W = 2;
  // reset values and data word width
  localparam logic [4:0] RST_LEN = 5'h08;
  localparam logic [IRQ_W-1:0] RST_MASK = 2'h0;
  localparam int WORD_W = 16;
endpackage

//--- tws_sync.sv
// two flip-flop synchroniser for pins arriving from outside the core clock
// assumes the pins are quiet for at least one core clock between changes
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- tws_slave.sv
// three-wire serial slave channel with a classic Wishbone register port
// assumes an external master drives the shift clock below one sixth of clk
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module tws_slave #(
  parameter int MIN_LEN = 7,
  parameter int MAX_LEN = 16,
  parameter int CH_IDX = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic shift_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic channel_event_irq
);
  localparam int W = tws_pkg::WORD_W;

  // clamp a programmed length to what this unit supports
  function automatic logic [4:0] clamp_len(input logic [4:0] v);
    if (v < 5'(MIN_LEN)) return 5'(MIN_LEN);
    if (v > 5'(MAX_LEN)) return 5'(MAX_LEN);
    return v;
  endfunction

  // next bit to launch from a transmit shifter
  function automatic logic tx_bit(input logic [W-1:0] sh, input logic [4:0] len,
                                 input logic lsbf);
    return lsbf ? sh[0] : sh[4'(len - 5'h01)];
  endfunction

  // shifter after one bit has gone
  function automatic logic [W-1:0] tx_step(input logic [W-1:0] sh, input logic lsbf);
    return lsbf ? {1'b0, sh[W-1:1]} : {sh[W-2:0], 1'b0};
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [W-1:0] merge16(input logic [W-1:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // configuration
  logic event_select_bit, tx_en, rx_en, running;
  logic [4:0] cfg_len;
  logic clock_polarity_sel, data_phase_sel, lsb_first;
  logic [tws_pkg::IRQ_W-1:0] irq_stat, irq_mask;
  // datapath
  logic [W-1:0] channel_data_buffer, tx_sh, rx_sh, rx_word;
  logic buffer_full_flag, tx_loaded, rx_valid;
  logic [4:0] tx_left, bit_cnt, len;
  logic sclk_s, sdi_s, sclk_q;
  logic wb_req, wb_acc, wr, rd;
  logic wr_data, wr_mode, wr_comm, wr_start, wr_stop, wr_istat, wr_imask, rd_data;
  logic start_p, k_now, k_prev, k_rise, k_fall, launch, capture, word_done, tx_move;
  logic ev_end, ev_empty;
  logic [31:0] rd_mux;

  // bus decode; writes and read side effects happen at the edge that sees ack
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_acc = wb_req & wb_ack_o;
  assign wr = wb_acc & wb_we_i;
  assign rd = wb_acc & ~wb_we_i;
  assign wr_data = wr && wb_adr_i == tws_pkg::OFS_DATA;
  assign wr_mode = wr && wb_adr_i == tws_pkg::OFS_MODE && wb_sel_i[0];
  assign wr_comm = wr && wb_adr_i == tws_pkg::OFS_COMM;
  assign wr_start = wr && wb_adr_i == tws_pkg::OFS_START;
  assign wr_stop = wr && wb_adr_i == tws_pkg::OFS_STOP;
  assign wr_istat = wr && wb_adr_i == tws_pkg::OFS_IRQ_STAT && wb_sel_i[0];
  assign wr_imask = wr && wb_adr_i == tws_pkg::OFS_IRQ_MASK && wb_sel_i[0];
  assign rd_data = rd && wb_adr_i == tws_pkg::OFS_DATA;
  // only this channel's bit starts it; other bits are ignored
  assign start_p = wr_start && wb_dat_i[CH_IDX];
  assign len = clamp_len(cfg_len);

  // pins come from the master's domain
  tws_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({shift_clock_pin, serial_in_pin}),
    .q({sclk_s, sdi_s})
  );

  // edges found by the core clock, hence the one-sixth bit rate ceiling
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= sclk_s;
    end
  end

  // polarity folds into the sampled clock; idle level of k is high
  assign k_now = sclk_s ^ clock_polarity_sel;
  assign k_prev = sclk_q ^ clock_polarity_sel;
  assign k_rise = k_now & ~k_prev;
  assign k_fall = ~k_now & k_prev;
  // phase 0 launches on the first edge, phase 1 preloads and launches on the second
  assign launch = running & (data_phase_sel ? k_rise : k_fall);
  assign capture = running & (data_phase_sel ? k_fall : k_rise);
  assign word_done = capture && bit_cnt == 5'(len - 5'h01);
  // buffer moves when the shifter is free or frees up in this cycle
  assign tx_move = running & tx_en & buffer_full_flag & (~tx_loaded | word_done);
  // event select is read live, so a mid-transfer change takes effect at once
  assign ev_empty = tx_en & event_select_bit & tx_move;
  // receive-only channels fall back to end-of-word whatever the select says
  assign ev_end = word_done & (~event_select_bit | ~tx_en);

  // wishbone ack: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      tws_pkg::OFS_DATA: rd_mux[W-1:0] = rx_word;
      tws_pkg::OFS_MODE: begin
        rd_mux[tws_pkg::MODE_EVSEL] = event_select_bit;
        rd_mux[tws_pkg::MODE_TX_EN] = tx_en;
        rd_mux[tws_pkg::MODE_RX_EN] = rx_en;
      end
      tws_pkg::OFS_COMM: begin
        rd_mux[tws_pkg::COMM_LEN_LSB +: tws_pkg::COMM_LEN_W] = cfg_len;
        rd_mux[tws_pkg::COMM_CPOL] = clock_polarity_sel;
        rd_mux[tws_pkg::COMM_DAP] = data_phase_sel;
        rd_mux[tws_pkg::COMM_LSBF] = lsb_first;
      end
      tws_pkg::OFS_STAT: begin
        rd_mux[tws_pkg::STAT_BFF] = buffer_full_flag;
        rd_mux[tws_pkg::STAT_BUSY] = tx_loaded | (bit_cnt != 5'h00);
        rd_mux[tws_pkg::STAT_RXV] = rx_valid;
        rd_mux[tws_pkg::STAT_OVF] = irq_stat[tws_pkg::IRQ_OVF];
      end
      tws_pkg::OFS_START: rd_mux[CH_IDX] = running;
      tws_pkg::OFS_IRQ_STAT: rd_mux[tws_pkg::IRQ_W-1:0] = irq_stat;
      tws_pkg::OFS_IRQ_MASK: rd_mux[tws_pkg::IRQ_W-1:0] = irq_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered at request so it stands while ack is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && wb_req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // mode, communication and interrupt mask configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_select_bit <= 1'b0;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      cfg_len <= tws_pkg::RST_LEN;
      clock_polarity_sel <= 1'b0;
      data_phase_sel <= 1'b0;
      lsb_first <= 1'b0;
      irq_mask <= tws_pkg::RST_MASK;
    end else if (ce) begin
      if (wr_mode) begin
        event_select_bit <= wb_dat_i[tws_pkg::MODE_EVSEL];
        tx_en <= wb_dat_i[tws_pkg::MODE_TX_EN];
        rx_en <= wb_dat_i[tws_pkg::MODE_RX_EN];
      end
      if (wr_comm && wb_sel_i[0]) begin
        cfg_len <= wb_dat_i[tws_pkg::COMM_LEN_LSB +: tws_pkg::COMM_LEN_W];
      end
      if (wr_comm && wb_sel_i[1]) begin
        clock_polarity_sel <= wb_dat_i[tws_pkg::COMM_CPOL];
        data_phase_sel <= wb_dat_i[tws_pkg::COMM_DAP];
        lsb_first <= wb_dat_i[tws_pkg::COMM_LSBF];
      end
      if (wr_imask) begin
        irq_mask <= wb_dat_i[tws_pkg::IRQ_W-1:0];
      end
    end
  end

  // channel run state: start bit sets, stop bit clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running <= 1'b0;
    end else if (ce) begin
      if (start_p) begin
        running <= 1'b1;
      end else if (wr_stop && wb_dat_i[CH_IDX]) begin
        running <= 1'b0;
      end
    end
  end

  // transmit buffer; a write while full overwrites the waiting word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_data_buffer <= '0;
      buffer_full_flag <= 1'b0;
    end else if (ce) begin
      if (wr_data && tx_en) begin
        channel_data_buffer <= merge16(channel_data_buffer, wb_dat_i, wb_sel_i);
        buffer_full_flag <= 1'b1;
      end else if (tx_move) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // transmit shifter; phase 1 puts the first bit out before the clock runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_sh <= '0;
      tx_left <= 5'h00;
      tx_loaded <= 1'b0;
      serial_out_pin <= 1'b0;
    end else if (ce) begin
      if (start_p) begin
        tx_left <= 5'h00;
        tx_loaded <= 1'b0;
      end else if (tx_move) begin
        tx_loaded <= 1'b1;
        if (data_phase_sel) begin
          serial_out_pin <= tx_bit(channel_data_buffer, len, lsb_first);
          tx_sh <= tx_step(channel_data_buffer, lsb_first);
          tx_left <= 5'(len - 5'h01);
        end else begin
          tx_sh <= channel_data_buffer;
          tx_left <= len;
        end
      end else begin
        if (word_done) begin
          tx_loaded <= 1'b0;
        end
        // bits only leave on edges of the master's clock
        if (launch && tx_left != 5'h00) begin
          serial_out_pin <= tx_bit(tx_sh, len, lsb_first);
          tx_sh <= tx_step(tx_sh, lsb_first);
          tx_left <= tx_left - 5'h01;
        end
      end
    end
  end

  // bit counter shared by both directions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= 5'h00;
    end else if (ce) begin
      if (start_p || word_done) begin
        bit_cnt <= 5'h00;
      end else if (capture) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // receive shifter and holding word; lsb-first fills from the top, so align at end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_sh <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
    end else if (ce) begin
      if (capture) begin
        rx_sh <= lsb_first ? {sdi_s, rx_sh[W-1:1]} : {rx_sh[W-2:0], sdi_s};
      end
      if (word_done && rx_en) begin
        // newest word wins; the unread one is lost and flagged
        rx_word <= lsb_first ? ({sdi_s, rx_sh[W-1:1]} >> (5'(W) - len))
                             : ({rx_sh[W-2:0], sdi_s} & ((W'(1) << len) - W'(1)));
        rx_valid <= 1'b1; // set wins over a read in the same cycle
      end else if (rd_data) begin
        rx_valid <= 1'b0;
      end
    end
  end

  // sticky event and overflow bits, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else if (ce) begin
      irq_stat[tws_pkg::IRQ_EVENT] <= (ev_end | ev_empty) |
        (irq_stat[tws_pkg::IRQ_EVENT] & ~(wr_istat & wb_dat_i[tws_pkg::IRQ_EVENT]));
      irq_stat[tws_pkg::IRQ_OVF] <= (word_done & rx_en & rx_valid & ~rd_data) |
        (irq_stat[tws_pkg::IRQ_OVF] & ~(wr_istat & wb_dat_i[tws_pkg::IRQ_OVF]));
    end
  end

  // level interrupt while any unmasked bit stands
  assign channel_event_irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

//--- tws_slave_properties.sv
// port checker for the serial slave channel
// assumes it is bound onto tws_slave and that ce stays high in the bench
`timescale 1ns/1ps
`default_nettype none
module tws_slave_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic shift_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic channel_event_irq
);
  logic [3:0] since;
  logic sclk_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last shift clock change or bus answer; saturates so it never wraps
  always_ff @(posedge clk) begin
    sclk_q <= shift_clock_pin;
    if (!rst_n || shift_clock_pin != sclk_q || wb_ack_o) begin
      since <= 4'h0;
    end else if (since != 4'hF) begin
      since <= since + 4'h1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_mask_off;
    wb_ack_o && wb_we_i && wb_adr_i == tws_pkg::OFS_IRQ_MASK && wb_sel_i[0]
      && wb_dat_i[1:0] == 2'h0;
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_reset_quiet: assert property ($rose(rst_n) |-> !wb_ack_o && !channel_event_irq
    && !serial_out_pin && wb_dat_o == 32'h0)
    else $error("outputs not at reset values");
  a_out_after_edge: assert property ($changed(serial_out_pin) |-> since < 4'h8)
    else $error("serial out moved without a shift clock edge");
  a_out_bit_hold: assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin)[*4])
    else $error("serial out bit held too briefly");
  a_irq_has_cause: assert property ($rose(channel_event_irq) |-> since < 4'h8)
    else $error("interrupt rose with no event");
  a_mask_kills_irq: assert property (s_mask_off |=> !channel_event_irq)
    else $error("interrupt high with every mask bit clear");
endmodule
bind tws_slave tws_slave_properties u_tws_slave_properties (
  .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shift_clock_pin(shift_clock_pin),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .channel_event_irq(channel_event_irq)
);
`default_nettype wire

//--- tws_master_model.sv
// behavioural serial master: makes the shift clock, drives data in, samples data out
// assumes the channel is set up and started before a frame is clocked
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
  output logic shift_clock_pin,
  output logic serial_in_pin,
  input wire logic serial_out_pin
);
  localparam time HALF = 160; // 320 ns period keeps each bit above six core clocks
  // clock idles still between frames
  initial begin
    shift_clock_pin = 1'b1;
    serial_in_pin = 1'b0;
  end
  // idle level of the clock follows polarity; only move it while the channel is stopped
  task park(input logic cpol);
    shift_clock_pin = ~cpol;
  endtask
  // one word; data out is sampled late because the slave needs up to three clocks to launch
  task automatic xfer(input int len, input logic cpol, input logic dap, input logic lsbf,
                      input logic [15:0] mo, output logic [15:0] got);
    int b;
    got = 16'h0;
    #13;
    if (dap) serial_in_pin = mo[lsbf ? 0 : len - 1];
    for (int i = 0; i < len; i++) begin
      b = lsbf ? i : len - 1 - i;
      shift_clock_pin = cpol;
      if (dap) begin // capture on the fall, launch on the rise
        #60 got[b] = serial_out_pin;
        #100 shift_clock_pin = ~cpol;
        if (i < len - 1) serial_in_pin = mo[lsbf ? i + 1 : len - 2 - i];
        #HALF;
      end else begin
        serial_in_pin = mo[b];
        #HALF shift_clock_pin = ~cpol;
        #60 got[b] = serial_out_pin;
        #100;
      end
    end
    serial_in_pin = ~serial_in_pin; // a released line no longer shows the last bit
  endtask
endmodule
`default_nettype wire

//--- tws_slave_tb_top.sv
// self-checking bench for the serial slave channel
// assumes the master model and the bound port checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); \
  end \
end
module tws_slave_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, rd, wb_dat_o;
  logic wb_ack, sclk, mosi, miso, irq;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int lens [8] = '{7, 16, 8, 12, 9, 15, 10, 13};
  always #20 clk = ~clk;
  tws_slave u_tws_slave (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .shift_clock_pin(sclk),
    .serial_in_pin(mosi), .serial_out_pin(miso), .channel_event_irq(irq));
  tws_master_model u_tws_master_model (.shift_clock_pin(sclk), .serial_in_pin(mosi),
    .serial_out_pin(miso));
  // one classic cycle; read data is taken at the ack edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, rd & m, e)
  endtask
  // full setup from a stopped channel, then start only our channel bit
  task automatic setup(input logic [31:0] mode, input logic [31:0] comm, input logic cpol);
    bus(1'b1, tws_pkg::OFS_STOP, 32'h1);
    bus(1'b1, tws_pkg::OFS_MODE, mode);
    bus(1'b1, tws_pkg::OFS_COMM, comm);
    u_tws_master_model.park(cpol);
    bus(1'b1, tws_pkg::OFS_IRQ_STAT, 32'h3);
    bus(1'b1, tws_pkg::OFS_START, 32'h1);
  endtask
  task t_reset;
    rchk(tws_pkg::OFS_COMM, '1, 32'h8, "comm");
    rchk(tws_pkg::OFS_MODE, '1, 32'h0, "mode");
    rchk(tws_pkg::OFS_STAT, '1, 32'h0, "status");
    rchk(tws_pkg::OFS_IRQ_MASK, '1, 32'h0, "mask");
    rchk(8'h20, '1, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  // every polarity, phase and order, with lengths across the range
  task automatic t_modes;
    logic [15:0] got, tx, rx, mk;
    for (int i = 0; i < 8; i++) begin
      mk = 16'((32'h1 << lens[i]) - 1);
      tx = 16'hA5C3 + 16'(i * 911);
      rx = 16'h3C96 - 16'(i * 577);
      setup(32'h6, 32'(lens[i]) | (32'(i) << 8), i[0]);
      bus(1'b1, tws_pkg::OFS_DATA, 32'(tx));
      u_tws_master_model.xfer(lens[i], i[0], i[1], i[2], rx, got);
      `CHK("tx word", got & mk, tx & mk)
      repeat (6) @(posedge clk);
      rchk(tws_pkg::OFS_DATA, 32'(mk), 32'(rx & mk), "rx word");
      rchk(tws_pkg::OFS_IRQ_STAT, '1, 32'h1, "end event");
    end
    $display("test modes done");
  endtask
  // writes while the shifter is busy; event select changes mid-word
  task automatic t_replace;
    logic [15:0] got;
    setup(32'h7, 32'h8, 1'b0);
    bus(1'b1, tws_pkg::OFS_DATA, 32'h5A);
    rchk(tws_pkg::OFS_IRQ_STAT, '1, 32'h1, "empty event");
    bus(1'b1, tws_pkg::OFS_IRQ_STAT, 32'h1);
    fork
      u_tws_master_model.xfer(8, 1'b0, 1'b0, 1'b0, 16'h11, got);
      begin
        repeat (10) @(posedge clk);
        bus(1'b1, tws_pkg::OFS_DATA, 32'hC3);
        rchk(tws_pkg::OFS_STAT, 32'h1, 32'h1, "full flag");
        bus(1'b1, tws_pkg::OFS_DATA, 32'h96);
        bus(1'b1, tws_pkg::OFS_MODE, 32'h6);
      end
    join
    `CHK("first word", got[7:0], 8'h5A)
    repeat (6) @(posedge clk);
    rchk(tws_pkg::OFS_IRQ_STAT, '1, 32'h1, "late end event");
    rchk(tws_pkg::OFS_DATA, 32'hFF, 32'h11, "first rx");
    u_tws_master_model.xfer(8, 1'b0, 1'b0, 1'b0, 16'h22, got);
    `CHK("replaced word", got[7:0], 8'h96)
    $display("test replace done");
  endtask
  // receive only with buffer-empty selected, two words left unread
  task automatic t_overrun;
    logic [15:0] got;
    setup(32'h5, 32'h8, 1'b0);
    u_tws_master_model.xfer(8, 1'b0, 1'b0, 1'b0, 16'hA5, got);
    u_tws_master_model.xfer(8, 1'b0, 1'b0, 1'b0, 16'h3C, got);
    repeat (6) @(posedge clk);
    rchk(tws_pkg::OFS_STAT, 32'hC, 32'hC, "overrun flag");
    rchk(tws_pkg::OFS_IRQ_STAT, '1, 32'h3, "rx events");
    `CHK("irq masked", irq, 1'b0)
    bus(1'b1, tws_pkg::OFS_IRQ_MASK, 32'h2);
    @(negedge clk);
    `CHK("irq raised", irq, 1'b1)
    bus(1'b1, tws_pkg::OFS_IRQ_STAT, 32'h2);
    @(negedge clk);
    `CHK("irq cleared", irq, 1'b0)
    bus(1'b1, tws_pkg::OFS_IRQ_MASK, 32'h3);
    bus(1'b1, tws_pkg::OFS_IRQ_MASK, 32'h0);
    rchk(tws_pkg::OFS_DATA, 32'hFF, 32'h3C, "newest word");
    $display("test overrun done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 1300 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_modes;
    t_replace;
    t_overrun;
    conclude;
  end
endmodule
`default_nettype wire
